// File: logic/btxc_top.sv
// Bonded transmit character control, pattern test latch and output enable latch
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module btxc_top
    import btxc_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    input  wire logic [BTXC_CHANS-1:0][1:0]    charCtlIn,
    input  wire logic [BTXC_CHANS-1:0][7:0]    txByteIn,
    input  wire logic [7:0]                    multiEnableIn,
    input  wire logic                          patternTestStrobe,
    input  wire logic                          outputEnableStrobe,
    input  wire logic                          rxPllEnableStrobe,
    output btxc_char_type [BTXC_CHANS-1:0]     charOut,
    output logic      [7:0]                    driverEnable,
    output logic      [7:0]                    driverForceOne,
    output logic      [BTXC_CHANS-1:0]         chanLowPower,
    output logic      [BTXC_CHANS-1:0]         txPatternActive,
    output logic      [BTXC_CHANS-1:0]         rxCheckerEnable,
    output logic      [BTXC_CHANS-1:0]         rxPllEnable
);

    localparam int PIN_W = 8 + 32 + 8 + 3;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [PIN_W-1:0]               pinMeta;
    logic [PIN_W-1:0]               pinSync;
    logic [BTXC_CHANS-1:0][1:0]     ctl;
    logic [BTXC_CHANS-1:0][7:0]     txByte;
    logic [7:0]                     enIn;
    logic                           bistStrobe;
    logic                           oeStrobe;
    logic                           pllStrobe;

    // Every control, byte, enable and strobe pin crosses in together so controls and bytes stay aligned
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= {charCtlIn, txByteIn, multiEnableIn,
                        patternTestStrobe, outputEnableStrobe, rxPllEnableStrobe};
            pinSync <= pinMeta;
        end
    end

    assign {ctl, txByte, enIn, bistStrobe, oeStrobe, pllStrobe} = pinSync;

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    logic [CTRL_W-1:0]              ctrl_reg;
    logic                           wrPend;
    logic [BTXC_ADDR_W-1:0]         wrAddr;
    logic                           addrPhase;
    logic [CTRL_W-1:0]              ctrlView;
    logic [31:0]                    readWord;
    logic [7:0]                     bistLatch;
    logic [7:0]                     oeLatch;
    logic [7:0]                     pllLatch;
    logic [BTXC_CHANS-1:0]          syncBusy;
    logic [1:0]                     bondLevel;
    logic [1:0]                     rxClkSel;
    logic                           loopback;

    assign addrPhase = hsel && htrans[1] && hready;
    assign bondLevel = ctrl_reg[CTRL_BOND_LSB +: 2];
    assign rxClkSel  = ctrl_reg[CTRL_CLK_LSB +: 2];
    assign loopback  = ctrl_reg[CTRL_LOCAL_LOOPBACK_ENABLE_BIT];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wrPend <= 1'b0;
            wrAddr <= '0;
        end else if (hready) begin
            wrPend <= addrPhase && hwrite;
            wrAddr <= haddr[BTXC_ADDR_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_reg <= CTRL_RST;
        end else if (wrPend && wrAddr == CTRL_OFFS) begin
            ctrl_reg <= hwdata[CTRL_W-1:0];
        end
    end

    // A read right behind a write to the same word sees the new value
    always_comb begin
        ctrlView = ctrl_reg;
        if (wrPend && wrAddr == CTRL_OFFS) begin
            ctrlView = hwdata[CTRL_W-1:0];
        end
        readWord = WORD_ZERO;
        case (haddr[BTXC_ADDR_W-1:0])
            CTRL_OFFS: begin
                readWord[CTRL_W-1:0] = ctrlView;
            end
            STAT_OFFS: begin
                readWord[STAT_BUILTIN_PATTERN_TEST_LSB +: 8]           = bistLatch;
                readWord[STAT_OE_LSB +: 8]             = oeLatch;
                readWord[STAT_SYNC_LSB +: BTXC_CHANS]  = syncBusy;
                readWord[STAT_PAT_LSB +: BTXC_CHANS]   = txPatternActive;
                readWord[STAT_RXPLL_LSB +: 8]          = pllLatch;
            end
            default: begin
                readWord = WORD_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hrdata <= WORD_ZERO;
        end else if (addrPhase && !hwrite) begin
            hrdata <= readWord;
        end
    end

    // Zero wait states and only OKAY answers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ************************************************************
    // Enable latches
    // ************************************************************
    // Transparent while the strobe is high, frozen from its fall
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bistLatch <= BUILTIN_PATTERN_TEST_RST;
        end else if (bistStrobe) begin
            bistLatch <= enIn;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            oeLatch <= OE_RST;
        end else if (oeStrobe) begin
            oeLatch <= enIn;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pllLatch <= RXPLL_RST;
        end else if (pllStrobe) begin
            pllLatch <= enIn;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            driverEnable    <= OE_RST;
            driverForceOne  <= '0;
            chanLowPower    <= '0;
            txPatternActive <= '0;
            rxCheckerEnable <= '0;
            rxPllEnable     <= '0;
        end else begin
            driverEnable   <= oeLatch;
            driverForceOne <= oeLatch & {8{loopback}};
            for (int c = 0; c < BTXC_CHANS; c++) begin
                chanLowPower[c]    <= !oeLatch[2*c] && !oeLatch[2*c+1];
                txPatternActive[c] <= !bistLatch[2*c+1];
                rxCheckerEnable[c] <= !bistLatch[2*c];
                rxPllEnable[c]     <= pllLatch[2*c];
            end
        end
    end

    // ************************************************************
    // Bonded character selection
    // ************************************************************
    logic [BTXC_CHANS-1:0][1:0]     selCode;
    logic [BTXC_CHANS-1:0]          forceSync;

    // Only the bits named per mapping are read, so the rest cannot leak in
    always_comb begin
        for (int c = 0; c < BTXC_CHANS; c++) begin
            selCode[c]   = ctl[c];
            forceSync[c] = 1'b0;
        end
        case (bondLevel)
            LEVEL_MID: begin
                selCode[0]   = {ctl[0][1], ctl[0][0]};
                selCode[1]   = {ctl[1][1], ctl[0][0]};
                selCode[2]   = {ctl[2][1], ctl[2][0]};
                selCode[3]   = {ctl[3][1], ctl[2][0]};
                forceSync[0] = ctl[1][0];
                forceSync[1] = ctl[1][0];
                forceSync[2] = ctl[3][0];
                forceSync[3] = ctl[3][0];
            end
            LEVEL_HIGH: begin
                for (int c = 0; c < BTXC_CHANS; c++) begin
                    selCode[c]   = {ctl[c][1], ctl[0][0]};
                    forceSync[c] = ctl[1][0];
                end
            end
            default: begin
                for (int c = 0; c < BTXC_CHANS; c++) begin
                    selCode[c] = ctl[c];
                end
            end
        endcase
    end

    // ************************************************************
    // Per-channel word sync and pattern sequencing
    // ************************************************************
    logic [BTXC_CHANS-1:0][3:0]         syncIdx;
    logic [BTXC_CHANS-1:0][LFSR_W-1:0]  lfsr;
    logic [BTXC_CHANS-1:0]              preDone;
    logic                               needPreamble;

    assign needPreamble = (rxClkSel != LEVEL_MID);

    function automatic logic [LFSR_W-1:0] lfsrStep(input logic [LFSR_W-1:0] s);
        // x^9 + x^5 + 1 is maximal, so the pass is 511 characters long
        lfsrStep = {s[LFSR_W-2:0], s[LFSR_W-1] ^ s[LFSR_TAP]};
    endfunction : lfsrStep

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            syncIdx  <= '0;
            syncBusy <= '0;
            lfsr     <= {BTXC_CHANS{LFSR_SEED}};
            preDone  <= '0;
            charOut  <= {BTXC_CHANS{CHAR_RST}};
        end else begin
            for (int c = 0; c < BTXC_CHANS; c++) begin
                if (syncBusy[c]) begin
                    // Atomic: inputs are not looked at until the 16th character
                    charOut[c].kind    <= KIND_SYNC;
                    charOut[c].value   <= FILL_CODE;
                    charOut[c].revDisp <= (syncIdx[c] == SYNC_REV_FIRST) ||
                                          (syncIdx[c] == SYNC_REV_LAST);
                    charOut[c].pattern <= 1'b0;
                    syncIdx[c]         <= syncIdx[c] + 4'h1;
                    syncBusy[c]        <= (syncIdx[c] != SYNC_LAST);
                end else if (!bistLatch[2*c+1]) begin
                    if (lfsr[c] == LFSR_SEED && needPreamble && !preDone[c]) begin
                        charOut[c]  <= '{KIND_SYNC, FILL_CODE, 1'b0, 1'b0};
                        syncIdx[c]  <= 4'h1;
                        syncBusy[c] <= 1'b1;
                        preDone[c]  <= 1'b1;
                    end else begin
                        // Top bit marks a special code so every code except data 00 appears
                        charOut[c].kind    <= lfsr[c][LFSR_W-1] ? KIND_SPECIAL
                                                                : KIND_DATA;
                        charOut[c].value   <= lfsr[c][7:0];
                        charOut[c].revDisp <= 1'b0;
                        charOut[c].pattern <= 1'b1;
                        lfsr[c]            <= lfsrStep(lfsr[c]);
                        if (lfsrStep(lfsr[c]) == LFSR_SEED) begin
                            preDone[c] <= 1'b0;
                        end
                    end
                end else begin
                    lfsr[c]    <= LFSR_SEED;
                    preDone[c] <= 1'b0;
                    if (forceSync[c] || selCode[c] == 2'b11) begin
                        charOut[c]  <= '{KIND_SYNC, FILL_CODE, 1'b0, 1'b0};
                        syncIdx[c]  <= 4'h1;
                        syncBusy[c] <= 1'b1;
                    end else begin
                        charOut[c].revDisp <= 1'b0;
                        charOut[c].pattern <= 1'b0;
                        case (selCode[c])
                            2'b00: begin
                                charOut[c].kind  <= KIND_DATA;
                                charOut[c].value <= txByte[c];
                            end
                            2'b01: begin
                                charOut[c].kind  <= KIND_FILL;
                                charOut[c].value <= FILL_CODE;
                            end
                            default: begin
                                charOut[c].kind  <= KIND_SPECIAL;
                                charOut[c].value <= txByte[c];
                            end
                        endcase
                    end
                end
            end
        end
    end

endmodule : btxc_top

// File: logic/btxc_pkg.sv
// Constants and types of the bonded transmit control block
package btxc_pkg;

    localparam int          BTXC_CHANS      = 4;
    localparam int          BTXC_ADDR_W     = 8;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  CTRL_OFFS       = 8'h00;
    localparam logic [7:0]  STAT_OFFS       = 8'h04;
    localparam int          CTRL_BOND_LSB   = 0;
    localparam int          CTRL_CLK_LSB    = 2;
    localparam int          CTRL_LOCAL_LOOPBACK_ENABLE_BIT   = 4;
    localparam int          CTRL_W          = 5;
    localparam logic [4:0]  CTRL_RST        = 5'h00;
    localparam int          STAT_BUILTIN_PATTERN_TEST_LSB   = 0;
    localparam int          STAT_OE_LSB     = 8;
    localparam int          STAT_SYNC_LSB   = 16;
    localparam int          STAT_PAT_LSB    = 20;
    localparam int          STAT_RXPLL_LSB  = 24;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
    // ************************************************************
    // Three-level select encodings
    // ************************************************************
    localparam logic [1:0]  LEVEL_LOW       = 2'h0;
    localparam logic [1:0]  LEVEL_MID       = 2'h1;
    localparam logic [1:0]  LEVEL_HIGH      = 2'h2;
    // ************************************************************
    // Character and sequence constants
    // ************************************************************
    localparam logic [7:0]  FILL_CODE       = 8'hBC;
    localparam logic [3:0]  SYNC_LAST       = 4'hF;
    localparam logic [3:0]  SYNC_REV_FIRST  = 4'h1;
    localparam logic [3:0]  SYNC_REV_LAST   = 4'h2;
    localparam int          LFSR_W          = 9;
    localparam logic [8:0]  LFSR_SEED       = 9'h1FF;
    localparam int          LFSR_TAP        = 4;
    localparam logic [7:0]  BUILTIN_PATTERN_TEST_RST        = 8'hFF;
    localparam logic [7:0]  OE_RST          = 8'h00;
    localparam logic [7:0]  RXPLL_RST       = 8'h00;

    typedef enum logic [1:0] {
        KIND_DATA,
        KIND_FILL,
        KIND_SPECIAL,
        KIND_SYNC
    } btxc_kind_type;

    typedef struct packed {
        btxc_kind_type kind;
        logic [7:0]    value;
        logic          revDisp;
        logic          pattern;
    } btxc_char_type;

    localparam btxc_char_type CHAR_RST = '{KIND_FILL, FILL_CODE, 1'b0, 1'b0};

endpackage : btxc_pkg

// File: test/btxc_checker.sv
// Concurrent checks on the ports of the bonded transmit control block
`timescale 1ns/100ps
module btxc_checker
    import btxc_pkg::*;
(
    input wire logic                          clk,
    input wire logic                          rst_b,
    input wire logic [7:0]                    multiEnableIn,
    input wire logic                          patternTestStrobe,
    input wire logic                          outputEnableStrobe,
    input wire btxc_char_type [BTXC_CHANS-1:0] charOut,
    input wire logic [7:0]                    driverEnable,
    input wire logic [7:0]                    driverForceOne,
    input wire logic [BTXC_CHANS-1:0]         chanLowPower,
    input wire logic [BTXC_CHANS-1:0]         txPatternActive,
    input wire logic [BTXC_CHANS-1:0]         rxCheckerEnable
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic syncA;
    assign syncA = (charOut[0].kind == KIND_SYNC);
    sequence syncHalf;
        syncA [*8];
    endsequence
    sequence revPair;
        !charOut[0].revDisp ##1 charOut[0].revDisp [*2] ##1 !charOut[0].revDisp;
    endsequence
    a_sync_full_run: assert property ($rose(syncA) |-> syncHalf ##1 syncHalf)
        else $error("word sync shorter than sixteen characters");
    a_sync_rev_disp: assert property ($rose(syncA) |-> revPair)
        else $error("word sync disparity marks misplaced");
    a_pattern_kinds: assert property (charOut[0].pattern |->
        charOut[0].kind inside {KIND_DATA, KIND_SPECIAL})
        else $error("pattern character of wrong kind");
    a_force_one_gated: assert property (driverForceOne != 8'h00 |->
        driverForceOne == driverEnable)
        else $error("forced one does not follow enabled drivers");
    a_low_power_pair: assert property ($past(rst_b) |-> chanLowPower ==
        ~{|driverEnable[7:6], |driverEnable[5:4], |driverEnable[3:2], |driverEnable[1:0]})
        else $error("low power flag disagrees with driver enables");
    a_oe_pass_through: assert property ((outputEnableStrobe && $stable(multiEnableIn)) [*6]
        |-> driverEnable == multiEnableIn)
        else $error("open output enable latch not transparent");
    a_oe_latch_hold: assert property ((!outputEnableStrobe) [*6] |-> $stable(driverEnable))
        else $error("closed output enable latch changed");
    a_test_pass_map: assert property ((patternTestStrobe && $stable(multiEnableIn)) [*6]
        |-> txPatternActive == ~{multiEnableIn[7], multiEnableIn[5], multiEnableIn[3],
        multiEnableIn[1]} && rxCheckerEnable == ~{multiEnableIn[6], multiEnableIn[4],
        multiEnableIn[2], multiEnableIn[0]})
        else $error("test enables not mapped from open latch");
    a_test_latch_hold: assert property ((!patternTestStrobe) [*6] |->
        $stable(txPatternActive))
        else $error("closed test latch changed");
endmodule : btxc_checker

bind btxc_top btxc_checker u_checker (.clk, .rst_b, .multiEnableIn, .patternTestStrobe,
    .outputEnableStrobe, .charOut, .driverEnable, .driverForceOne, .chanLowPower,
    .txPatternActive, .rxCheckerEnable);

// File: test/btxc_host_model.sv
// Host logic that drives the parallel control, byte and enable pins
`timescale 1ns/100ps
module btxc_host_model
    import btxc_pkg::*;
(
    input  wire logic                        clk,
    output logic [BTXC_CHANS-1:0][1:0]       charCtlIn,
    output logic [BTXC_CHANS-1:0][7:0]       txByteIn,
    output logic [7:0]                       multiEnableIn,
    output logic                             patternTestStrobe,
    output logic                             outputEnableStrobe,
    output logic                             rxPllEnableStrobe
);
    // ************************************************************
    // Pin drive
    // ************************************************************
    // Bytes stay fixed per channel so data characters can be traced back
    initial begin
        charCtlIn = 8'h11;
        txByteIn = 32'hA3A2_A1A0;
        multiEnableIn = 8'hFF;
        {rxPllEnableStrobe, outputEnableStrobe, patternTestStrobe} = 3'b000;
    end
    task automatic set_ctl(input logic [7:0] v);
        @(posedge clk);
        charCtlIn <= v;
    endtask : set_ctl
    // Link data after re-enabling a channel is never trusted here, it only sets pins
    task automatic set_en(input logic [7:0] v, input logic [2:0] stb);
        @(posedge clk);
        multiEnableIn <= v;
        {rxPllEnableStrobe, outputEnableStrobe, patternTestStrobe} <= stb;
    endtask : set_en
endmodule : btxc_host_model

// File: test/testbench.sv
// Self-checking testbench of the bonded transmit control block
`timescale 1ns/100ps
module testbench;
    import btxc_pkg::*;
    // ************************************************************
    // Bench signals and tasks
    // ************************************************************
    logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [3:0][1:0] charCtlIn;
    logic [3:0][7:0] txByteIn;
    logic [7:0] multiEnableIn, driverEnable, driverForceOne;
    logic patternTestStrobe, outputEnableStrobe, rxPllEnableStrobe;
    btxc_char_type [3:0] charOut;
    logic [3:0] chanLowPower, txPatternActive, rxCheckerEnable, rxPllEnable;
    int fail_count = 0;
    int compares = 0;
    btxc_host_model host (.clk, .charCtlIn, .txByteIn, .multiEnableIn, .patternTestStrobe,
        .outputEnableStrobe, .rxPllEnableStrobe);
    btxc_top dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .charCtlIn, .txByteIn, .multiEnableIn,
        .patternTestStrobe, .outputEnableStrobe, .rxPllEnableStrobe, .charOut, .driverEnable,
        .driverForceOne, .chanLowPower, .txPatternActive, .rxCheckerEnable, .rxPllEnable);
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic end_of_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check_val
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            check_val("hreadyout", 32'h1, {31'h0, hreadyout});
            end_of_test();
        end
    endtask : wait_ready
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
        check_val("hresp", 32'h0, {31'h0, hresp});
    endtask : bus
    task automatic test_reset();
        logic [31:0] r;
        bus(STAT_OFFS, 1'b0, WORD_ZERO, r);
        check_val("testLatch", {24'h0, BUILTIN_PATTERN_TEST_RST}, {24'h0, r[7:0]});
        bus(STAT_OFFS, 1'b1, WORD_ZERO, r);
        bus(STAT_OFFS, 1'b0, WORD_ZERO, r);
        check_val("statusKept", {24'h0, BUILTIN_PATTERN_TEST_RST}, {24'h0, r[7:0]});
        bus(8'h10, 1'b0, WORD_ZERO, r);
        check_val("unmapped", WORD_ZERO, r);
        $display("test reset done");
    endtask : test_reset
    // Waiting twenty characters lets any running word sync finish first
    task automatic map_check(input logic [1:0] mode);
        logic [31:0] r;
        logic [3:0][1:0] e;
        bus(CTRL_OFFS, 1'b1, {28'h0, LEVEL_MID, mode}, r);
        for (int i = 0; i < 16; i++) begin
            host.set_ctl({i[0], mode == LEVEL_HIGH ? i[3] : 1'b0, i[1], i[3],
                i[1], 1'b0, i[0], i[2]});
            repeat (20) @(posedge clk);
            #1;
            e[0] = {i[0], i[2]};
            e[1] = {i[1], (mode == LEVEL_LOW) ? 1'b0 : i[2]};
            e[2] = (mode == LEVEL_HIGH) ? {i[1], i[2]} : {i[1], i[3]};
            e[3] = (mode == LEVEL_HIGH) ? {i[0], i[2]}
                 : {i[0], (mode == LEVEL_LOW) ? 1'b0 : i[3]};
            for (int c = 0; c < 4; c++) begin
                check_val("kind", {30'h0, e[c]}, {30'h0, charOut[c].kind});
                if (e[c] == 2'b00) begin
                    check_val("value", 32'hA0 + c, {24'h0, charOut[c].value});
                end
            end
        end
        $display("test map done");
    endtask : map_check
    task automatic sync_check(input logic [1:0] mode, input int ch, input logic [3:0] mask);
        logic [31:0] r;
        bus(CTRL_OFFS, 1'b1, {28'h0, LEVEL_MID, mode}, r);
        host.set_ctl(8'h11);
        repeat (20) @(posedge clk);
        host.set_ctl(8'h11 | 8'(1 << (2 * ch)));
        host.set_ctl(8'h11);
        repeat (2) @(posedge clk);
        for (int k = 0; k < 17; k++) begin
            #1;
            for (int c = 0; c < 4; c++) begin
                check_val("kind", (mask[c] && k < 16) ? 32'h3 : 32'h1, {30'h0, charOut[c].kind});
                check_val("revDisp", {31'h0, mask[c] && (k == 1 || k == 2)},
                    {31'h0, charOut[c].revDisp});
            end
            @(posedge clk);
        end
        $display("test sync done");
    endtask : sync_check
    task automatic oe_check();
        logic [31:0] r;
        host.set_en(8'h0F, 3'b010);
        repeat (6) @(posedge clk);
        #1;
        check_val("driverEnable", 32'h0F, {24'h0, driverEnable});
        check_val("chanLowPower", 32'hC, {28'h0, chanLowPower});
        host.set_en(8'hF0, 3'b100);
        repeat (6) @(posedge clk);
        #1;
        check_val("driverEnable", 32'h0F, {24'h0, driverEnable});
        check_val("rxPllEnable", 32'hC, {28'h0, rxPllEnable});
        bus(CTRL_OFFS, 1'b1, 32'h0000_0015, r);
        repeat (3) @(posedge clk);
        #1;
        check_val("driverForceOne", 32'h0F, {24'h0, driverForceOne});
        $display("test output enable done");
    endtask : oe_check
    task automatic builtin_pattern_test_check();
        logic [31:0] r;
        logic [9:0] pat [$];
        int syncs;
        int fills;
        bus(CTRL_OFFS, 1'b1, 32'h0000_0001, r);
        host.set_en(8'hFD, 3'b001);
        repeat (7) @(posedge clk);
        #1;
        check_val("txPatternActive", 32'h1, {28'h0, txPatternActive});
        check_val("rxCheckerEnable", 32'h0, {28'h0, rxCheckerEnable});
        host.set_en(8'hFF, 3'b000);
        syncs = 0;
        fills = 0;
        for (int k = 0; k < 600; k++) begin
            @(posedge clk);
            #1;
            if (charOut[0].pattern === 1'b1) begin
                pat.push_back({charOut[0].kind, charOut[0].value});
            end else if (pat.size() > 0 && pat.size() < 512 && charOut[0].kind === KIND_SYNC) begin
                syncs++;
            end
            fills += (charOut[0].kind === KIND_FILL);
        end
        check_val("txPatternActive", 32'h1, {28'h0, txPatternActive});
        check_val("preamble", 32'd16, syncs);
        check_val("fills", 32'd0, fills);
        check_val("period", {22'h0, pat[0]}, {22'h0, pat[511]});
        check_val("period", {22'h0, pat[1]}, {22'h0, pat[512]});
        check_val("step", 32'h1, {31'h0, pat[0] !== pat[1]});
        // Middle receive clock level: the next pass must start with no word sync
        bus(CTRL_OFFS, 1'b1, 32'h0000_0005, r);
        syncs = 0;
        for (int k = 0; k < 530; k++) begin
            @(posedge clk);
            #1;
            syncs += (charOut[0].kind === KIND_SYNC);
        end
        check_val("noPreamble", 32'd0, syncs);
        $display("test pattern done");
    endtask : builtin_pattern_test_check
    initial begin
        repeat (4) @(posedge clk);
        #1;
        check_val("charOut", {20'h0, CHAR_RST}, {20'h0, charOut[0]});
        check_val("driverEnable", {24'h0, OE_RST}, {24'h0, driverEnable});
        check_val("txPatternActive", 32'h0, {28'h0, txPatternActive});
        @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        test_reset();
        map_check(LEVEL_LOW);
        map_check(LEVEL_MID);
        map_check(LEVEL_HIGH);
        sync_check(LEVEL_MID, 1, 4'h3);
        sync_check(LEVEL_MID, 3, 4'hC);
        sync_check(LEVEL_HIGH, 1, 4'hF);
        sync_check(LEVEL_HIGH, 3, 4'h0);
        oe_check();
        builtin_pattern_test_check();
        end_of_test();
    end
endmodule : testbench
